//--- logic/watchdog_interval_timer.sv
// watchdog and interval timer with keyed register writes
//
// Operation
// - 8-bit up-counter increments on selected prescaler pulse while enabled
// - wrap from ff to 00 raises overflow output or interrupt by mode
// - counter cleared on reset and while disabled; held through standby
// - control bits 7..5 cleared on reset and standby; clock select only reset
// - interval flag set on wrap in interval mode; cleared by read-1 then write-0
// - mode 0 requests interval interrupt; mode 1 drives overflow output
// - enable 0 holds counter at zero; enable 1 counts and signals overflow
// - reserved bits read as one; software writes ones
// - clock select picks divide by 2,64,128,256,512,1024,4096,8192
// - reset control loads 1f on pin reset and standby, not on own reset
// - watchdog flag set on wrap in watchdog mode; read-1 then write-0 clears
// - chip reset enable issues internal reset; otherwise counter and control reset
// - reset type select: 0 power-on, 1 manual
// - registers written only by 16-bit word writes
// - registers read by byte transfers
// - decoder compares address bits 27..24 and 8..0 only
// - keyed word write loads counter (5a) or control (a5)
// - reset control: a5/00 clears flag; 5a loads enable and type bits
// - overflow output asserted 128 cycles on watchdog overflow
// - internal chip reset held 512 cycles
`timescale 1ns/1ns
`default_nettype none
module watchdog_interval_timer
   import wdt_pkg::*;
(
   // clock and resets
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic        standby,
   // cpu bus
   input  wire logic [27:0] busAddr,
   input  wire logic        busWrite,
   input  wire logic        busRead,
   input  wire logic [1:0]  busSize,
   input  wire logic [15:0] busWdata,
   output logic      [7:0]  busRdata_q,
   // events
   output logic             overflow_out_n,
   output logic             interval_interrupt,
   output logic             chipReset_q,
   output logic             chipResetManual_q
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic hit(input logic [27:0] a, input logic [27:0] r);
      hit = ((a ^ r) & ADDR_MASK) == 28'h0000000;
   endfunction : hit

   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_WORD = 2'h1;

   logic [7:0]  count_reg_q;
   logic        flagOvf_q;
   logic        mode_q;
   logic        enable_q;
   logic [2:0]  clkSel_q;
   logic        flagWovf_q;
   logic        chip_reset_enable_q;
   logic        reset_type_select_q;
   logic        ovfRead_q;
   logic        wovfRead_q;
   logic [PRESC_W-1:0] presc_q;
   logic [PRESC_W-1:0] prescPrev_q;
   logic [9:0]  ovfCnt_q;
   logic [9:0]  rstCnt_q;
   logic        ownReset_q;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   logic wrWord;
   logic rdByte;
   logic wrCount;
   logic wrCtrl;
   logic wrRClear;
   logic wrRBits;
   logic rdCtrl;
   logic rdRctrl;
   assign wrWord   = busWrite && busSize == SZ_WORD;
   assign rdByte   = busRead && busSize == SZ_BYTE;
   assign wrCount  = wrWord && hit(busAddr, ADDR_COUNT & ~28'h1)
                     && busWdata[15:8] == KEY_COUNT;
   assign wrCtrl   = wrWord && hit(busAddr, ADDR_CTRL_STATUS)
                     && busWdata[15:8] == KEY_CTRL;
   assign wrRClear = wrWord && hit(busAddr, ADDR_RESET_CTRL)
                     && busWdata[15:8] == KEY_CTRL
                     && busWdata[7:0] == CLEAR_DATA;
   assign wrRBits  = wrWord && hit(busAddr, ADDR_RESET_CTRL)
                     && busWdata[15:8] == KEY_COUNT;
   assign rdCtrl   = rdByte && hit(busAddr, ADDR_CTRL_STATUS);
   assign rdRctrl  = rdByte && hit(busAddr, ADDR_RESET_RD);

   // ----------------------------------------
   // prescaler and tick
   // ----------------------------------------
   // free running; a tick is a rising edge of the selected tap
   logic [3:0] tap;
   logic       tick;
   always_comb
   begin
      unique case (clkSel_q)
         3'h0: tap = 4'h0;
         3'h1: tap = 4'h5;
         3'h2: tap = 4'h6;
         3'h3: tap = 4'h7;
         3'h4: tap = 4'h8;
         3'h5: tap = 4'h9;
         3'h6: tap = 4'hb;
         3'h7: tap = 4'hc;
      endcase
   end
   assign tick = presc_q[tap] && !prescPrev_q[tap];

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         presc_q     <= '0;
         prescPrev_q <= '0;
      end
      else
      begin
         presc_q     <= presc_q + 1'b1;
         prescPrev_q <= presc_q;
      end
   end

   logic wrap;
   assign wrap = enable_q && tick && count_reg_q == 8'hff && !wrCount;

   // ----------------------------------------
   // counter
   // ----------------------------------------
   // a write wins over a coincident increment
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b || ownReset_q)
         count_reg_q <= COUNT_RESET;
      else if (standby)
         count_reg_q <= count_reg_q;
      else if (wrCount)
         count_reg_q <= busWdata[7:0];
      else if (!enable_q)
         count_reg_q <= COUNT_RESET;
      else if (tick)
         count_reg_q <= count_reg_q + 8'h01;
   end

   // ----------------------------------------
   // control/status
   // ----------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b || ownReset_q)
      begin
         flagOvf_q <= 1'b0;
         mode_q    <= 1'b0;
         enable_q  <= 1'b0;
         clkSel_q  <= CTRL_RESET[2:0];
         ovfRead_q <= 1'b0;
      end
      else if (standby)
      begin
         flagOvf_q <= 1'b0;
         mode_q    <= 1'b0;
         enable_q  <= 1'b0;
         ovfRead_q <= 1'b0;
      end
      else
      begin
         if (rdCtrl && flagOvf_q)
            ovfRead_q <= 1'b1;
         if (wrap && !mode_q)
            flagOvf_q <= 1'b1; // set wins over clear
         else if (wrCtrl && !busWdata[BIT_FLAG] && ovfRead_q)
         begin
            flagOvf_q <= 1'b0;
            ovfRead_q <= 1'b0;
         end
         if (wrCtrl)
         begin
            mode_q   <= busWdata[BIT_MODE];
            enable_q <= busWdata[BIT_ENABLE];
            clkSel_q <= busWdata[2:0];
         end
      end
   end

   // ----------------------------------------
   // reset control/status
   // ----------------------------------------
   // untouched by the block's own chip reset
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b || standby)
      begin
         flagWovf_q <= RCTRL_RESET[BIT_FLAG];
         chip_reset_enable_q     <= RCTRL_RESET[BIT_CHIP_RESET_ENABLE];
         reset_type_select_q     <= RCTRL_RESET[BIT_RESET_TYPE_SELECT];
         wovfRead_q <= 1'b0;
      end
      else
      begin
         if (rdRctrl && flagWovf_q)
            wovfRead_q <= 1'b1;
         if (wrap && mode_q)
            flagWovf_q <= 1'b1;
         else if (wrRClear && wovfRead_q)
         begin
            flagWovf_q <= 1'b0;
            wovfRead_q <= 1'b0;
         end
         if (wrRBits)
         begin
            chip_reset_enable_q <= busWdata[BIT_CHIP_RESET_ENABLE];
            reset_type_select_q <= busWdata[BIT_RESET_TYPE_SELECT];
         end
      end
   end

   // ----------------------------------------
   // overflow output and chip reset pulses
   // ----------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         ovfCnt_q       <= '0;
         overflow_out_n <= 1'b1;
      end
      else if (wrap && mode_q)
      begin
         ovfCnt_q       <= OVF_OUT_CNT;
         overflow_out_n <= 1'b0;
      end
      else if (ovfCnt_q != 10'h000)
         ovfCnt_q <= ovfCnt_q - 10'h001;
      else
         overflow_out_n <= 1'b1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         rstCnt_q          <= '0;
         chipReset_q       <= 1'b0;
         chipResetManual_q <= 1'b0;
         ownReset_q        <= 1'b0;
      end
      else
      begin
         // one-cycle local clear of counter and control when not resetting chip
         ownReset_q <= wrap && mode_q && !chip_reset_enable_q;
         if (wrap && mode_q && chip_reset_enable_q)
         begin
            rstCnt_q          <= CHIP_RST_CNT;
            chipReset_q       <= 1'b1;
            chipResetManual_q <= reset_type_select_q;
         end
         else if (rstCnt_q != 10'h000)
            rstCnt_q <= rstCnt_q - 10'h001;
         else
            chipReset_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         interval_interrupt <= 1'b0;
      else
         interval_interrupt <= flagOvf_q || (wrap && !mode_q);
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         busRdata_q <= 8'h00;
      else if (rdCtrl)
         busRdata_q <= {flagOvf_q, mode_q, enable_q, 2'b00, clkSel_q}
                       | CTRL_RSVD;
      else if (rdByte && hit(busAddr, ADDR_COUNT))
         busRdata_q <= count_reg_q;
      else if (rdRctrl)
         busRdata_q <= {flagWovf_q, chip_reset_enable_q, reset_type_select_q, 5'h00} | RCTRL_RSVD;
      else
         busRdata_q <= 8'h00;
   end

endmodule : watchdog_interval_timer
`default_nettype wire

//--- logic/wdt_pkg.sv
// constants for the watchdog / interval timer
package wdt_pkg;
   // ----------------------------------------
   // register addresses (bits 27..24 and 8..0 decoded)
   // ----------------------------------------
   localparam logic [27:0] ADDR_CTRL_STATUS = 28'h5ffffb8;
   localparam logic [27:0] ADDR_COUNT       = 28'h5ffffb9;
   localparam logic [27:0] ADDR_RESET_CTRL  = 28'h5ffffba;
   localparam logic [27:0] ADDR_RESET_RD    = 28'h5ffffbb;
   localparam logic [27:0] ADDR_MASK        = 28'hf0001ff;
   // ----------------------------------------
   // write keys
   // ----------------------------------------
   localparam logic [7:0] KEY_COUNT  = 8'h5a;
   localparam logic [7:0] KEY_CTRL   = 8'ha5;
   localparam logic [7:0] CLEAR_DATA = 8'h00;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int BIT_FLAG   = 7;
   localparam int BIT_MODE   = 6;
   localparam int BIT_ENABLE = 5;
   localparam int BIT_CHIP_RESET_ENABLE   = 6;
   localparam int BIT_RESET_TYPE_SELECT   = 5;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] CTRL_RESET  = 8'h18;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] RCTRL_RESET = 8'h1f;
   localparam logic [7:0] CTRL_RSVD   = 8'h18;
   localparam logic [7:0] RCTRL_RSVD  = 8'h1f;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_NS         = 100;
   localparam int OVF_OUT_CYCLES = 128;
   localparam int CHIP_RST_CYCLES = 512;
   localparam logic [9:0] OVF_OUT_CNT  = 10'(OVF_OUT_CYCLES - 1);
   localparam logic [9:0] CHIP_RST_CNT = 10'(CHIP_RST_CYCLES - 1);
   localparam int PRESC_W = 13;
endpackage : wdt_pkg

//--- sim/wdt_asserts.sv
// port checker for the watchdog interval timer
`timescale 1ns/1ns
`default_nettype none
module wdt_asserts
   import wdt_pkg::*;
(
   // clock, resets and bus
   input wire logic        sys_clk,
   input wire logic        rst_b,
   input wire logic        standby,
   input wire logic [27:0] busAddr,
   input wire logic        busWrite,
   input wire logic        busRead,
   input wire logic [1:0]  busSize,
   input wire logic [15:0] busWdata,
   input wire logic [7:0]  busRdata_q,
   // events
   input wire logic        overflow_out_n,
   input wire logic        interval_interrupt,
   input wire logic        chipReset_q,
   input wire logic        chipResetManual_q
);
   logic [9:0] lowCnt_q;
   logic [9:0] hiCnt_q;
   logic       rdByte;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   assign rdByte = busRead && busSize == 2'd0;
   // pulse lengths are counted, too long for a repetition
   always_ff @(posedge sys_clk)
      lowCnt_q <= (!rst_b || overflow_out_n) ? 10'h000 : lowCnt_q + 10'h001;
   always_ff @(posedge sys_clk)
      hiCnt_q <= (!rst_b || !chipReset_q) ? 10'h000 : hiCnt_q + 10'h001;
   sequence s_rd_rctrl;
      rdByte && (busAddr & ADDR_MASK) == ADDR_RESET_RD;
   endsequence
   sequence s_standby_rd;
      standby ##[1:2] s_rd_rctrl;
   endsequence
   a_rdata_idle: assert property (!busRead |=> busRdata_q == 8'h00)
      else $error("read data not zero when idle");
   a_read_wide: assert property (busRead && busSize != 2'd0 |=> busRdata_q == 8'h00)
      else $error("wide read returned data");
   a_rsvd_ctrl: assert property (rdByte && (busAddr & ADDR_MASK) == ADDR_CTRL_STATUS
      |=> busRdata_q[4:3] == 2'b11)
      else $error("control reserved bits not one");
   a_rsvd_rctrl: assert property (s_rd_rctrl |=> busRdata_q[4:0] == 5'h1f)
      else $error("reset control reserved bits not one");
   a_standby_rctrl: assert property (s_standby_rd |=> busRdata_q == RCTRL_RESET)
      else $error("reset control not reloaded by standby");
   a_ovf_length: assert property ($rose(overflow_out_n) |-> lowCnt_q == 10'd128)
      else $error("overflow output low time wrong");
   a_chip_rst_len: assert property ($fell(chipReset_q) |-> hiCnt_q == 10'd512)
      else $error("chip reset high time wrong");
   a_rst_with_ovf: assert property ($rose(chipReset_q) |-> $fell(overflow_out_n))
      else $error("chip reset not with overflow output");
   a_irq_drop_cause: assert property ($fell(interval_interrupt) |-> $past(busWrite)
      || $past(busWrite, 2) || $past(standby) || $past(standby, 2))
      else $error("interrupt dropped without clear");
endmodule : wdt_asserts
bind watchdog_interval_timer wdt_asserts u_wdt_asserts (.sys_clk(sys_clk),
   .rst_b(rst_b), .standby(standby), .busAddr(busAddr), .busWrite(busWrite),
   .busRead(busRead), .busSize(busSize), .busWdata(busWdata),
   .busRdata_q(busRdata_q), .overflow_out_n(overflow_out_n),
   .interval_interrupt(interval_interrupt), .chipReset_q(chipReset_q),
   .chipResetManual_q(chipResetManual_q));
`default_nettype wire

//--- sim/cpu_bus_model.sv
// behavioural cpu master on the timer register bus
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_model
(
   // clock and read return
   input  wire logic        sys_clk,
   input  wire logic [7:0]  busRdata_q,
   // request
   output var  logic [27:0] busAddr  = 28'h0000000,
   output var  logic        busWrite = 1'b0,
   output var  logic        busRead  = 1'b0,
   output var  logic [1:0]  busSize  = 2'd0,
   output var  logic [15:0] busWdata = 16'h0000
);
   // one access: one-cycle strobe, data taken the cycle after
   task xfer(input logic [27:0] a, input logic [1:0] sz, input logic wr,
             input logic [15:0] d, output logic [7:0] q);
      @(posedge sys_clk);
      busAddr  <= a;
      busSize  <= sz;
      busWdata <= d;
      busWrite <= wr;
      busRead  <= !wr;
      @(posedge sys_clk);
      busWrite <= 1'b0;
      busRead  <= 1'b0;
      // released lines must not keep showing the last value
      busAddr  <= ~a;
      busWdata <= ~d;
      #1 q = busRdata_q;
   endtask : xfer
endmodule : cpu_bus_model
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench for the watchdog interval timer
`timescale 1ns/1ns
`default_nettype none
module testbench
   import wdt_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst_b   = 1'b0;
   logic standby = 1'b0;
   logic m       = 1'b0;
   logic [27:0] busAddr;
   logic        busWrite, busRead;
   logic [1:0]  busSize;
   logic [15:0] busWdata;
   logic [7:0]  busRdata_q, q;
   logic        ovfN, irq, chipRst, chipMan;
   int fail_count = 0;
   int cmp_count  = 0;
   int n, lo, hi, k, r;
   int div[8] = '{2, 64, 128, 256, 512, 1024, 4096, 8192};
   initial forever #50 sys_clk = ~sys_clk;
   watchdog_interval_timer u_watchdog_interval_timer (.sys_clk(sys_clk),
      .rst_b(rst_b), .standby(standby), .busAddr(busAddr),
      .busWrite(busWrite), .busRead(busRead), .busSize(busSize),
      .busWdata(busWdata), .busRdata_q(busRdata_q), .overflow_out_n(ovfN),
      .interval_interrupt(irq), .chipReset_q(chipRst),
      .chipResetManual_q(chipMan));
   cpu_bus_model u_cpu_bus_model (.sys_clk(sys_clk), .busRdata_q(busRdata_q),
      .busAddr(busAddr), .busWrite(busWrite), .busRead(busRead),
      .busSize(busSize), .busWdata(busWdata));
   task check(input logic [7:0] seen, input logic [7:0] e);
      cmp_count++;
      if (seen !== e)
      begin
         $display("[FAIL] %0t seen %h expected %h", $time, seen, e);
         fail_count++;
      end
   endtask : check
   task conclude;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude
   task wr(input logic [27:0] a, input logic [15:0] d);
      u_cpu_bus_model.xfer(a, 2'd1, 1'b1, d, q);
   endtask : wr
   task rdc(input logic [27:0] a, input logic [7:0] e);
      u_cpu_bus_model.xfer(a, 2'd0, 1'b0, 16'h0000, q);
      check(q, e);
   endtask : rdc
   initial
   begin
      r = $urandom(86509);
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      rdc(ADDR_CTRL_STATUS, CTRL_RESET);
      rdc(ADDR_COUNT, COUNT_RESET);
      rdc(ADDR_RESET_RD, RCTRL_RESET);
      r = $urandom;
      // address bits 23..9 are don't care to the decoder
      wr(ADDR_CTRL_STATUS | {4'h0, 15'(r), 9'h000}, {KEY_CTRL, 8'h3f});
      wr(ADDR_CTRL_STATUS | {4'h0, 15'(r >> 15), 9'h000}, {KEY_COUNT, 8'(r)});
      rdc(ADDR_COUNT, 8'(r));
      wr(ADDR_CTRL_STATUS, {KEY_CTRL, 8'h18});
      rdc(ADDR_COUNT, 8'h00);
      u_cpu_bus_model.xfer(ADDR_CTRL_STATUS, 2'd0, 1'b1, 16'ha53f, q);
      rdc(ADDR_CTRL_STATUS, CTRL_RESET);
      u_cpu_bus_model.xfer(ADDR_CTRL_STATUS, 2'd2, 1'b0, 16'h0000, q);
      check(q, 8'h00);
      for (k = 0; k < 8; k++)
      begin
         wr(ADDR_CTRL_STATUS, {KEY_CTRL, 8'h18 | 8'(k)});
         wr(ADDR_CTRL_STATUS, {KEY_CTRL, 8'h38 | 8'(k)});
         wr(ADDR_CTRL_STATUS, {KEY_COUNT, 8'hfe});
         n = 0;
         while (irq !== 1'b1 && n < 20000)
         begin
            @(posedge sys_clk);
            #1 n++;
         end
         if (n >= 20000)
         begin
            fail_count++;
            conclude();
         end
         check(8'(n > div[k] && n <= 2 * div[k] + 8), 8'h01);
         rdc(ADDR_CTRL_STATUS, 8'hb8 | 8'(k));
         wr(ADDR_CTRL_STATUS, {KEY_CTRL, 8'h38 | 8'(k)});
         repeat (2) @(posedge sys_clk);
         #1 check({7'h0, irq}, 8'h00);
      end
      rdc(ADDR_RESET_RD, RCTRL_RESET);
      for (k = 0; k < 2; k++)
      begin
         r = $urandom & 1;
         wr(ADDR_RESET_CTRL, {KEY_COUNT, 8'(k * 64 + r * 32) | 8'h1f});
         wr(ADDR_CTRL_STATUS, {KEY_CTRL, 8'h1f});
         wr(ADDR_CTRL_STATUS, {KEY_CTRL, 8'h7f});
         wr(ADDR_CTRL_STATUS, {KEY_COUNT, 8'hff});
         lo = 0;
         hi = 0;
         m  = 1'b0;
         for (n = 0; n < 9000; n++)
         begin
            @(posedge sys_clk);
            #1 lo += int'(ovfN === 1'b0);
            hi += int'(chipRst === 1'b1);
            if (chipRst === 1'b1)
               m = chipMan;
         end
         check(8'(lo), 8'h80);
         check(8'(hi >> 2), 8'(k * 128));
         check({7'h0, m}, 8'(k & r));
         rdc(ADDR_RESET_RD, 8'h9f | 8'(k * 64 + r * 32));
         if (k == 0)
            rdc(ADDR_CTRL_STATUS, CTRL_RESET);
         wr(ADDR_RESET_CTRL, {KEY_CTRL, CLEAR_DATA});
         rdc(ADDR_RESET_RD, 8'h1f | 8'(k * 64 + r * 32));
      end
      @(posedge sys_clk);
      standby <= 1'b1;
      @(posedge sys_clk);
      standby <= 1'b0;
      rdc(ADDR_RESET_RD, RCTRL_RESET);
      rdc(ADDR_CTRL_STATUS, 8'h1f);
      conclude();
   end
endmodule : testbench
`default_nettype wire
